// >>> src/pmic_rail_config_defines.vh
`ifndef PMIC_RAIL_CONFIG_DEFINES_VH
`define PMIC_RAIL_CONFIG_DEFINES_VH
// Overview of operation
// - Link config bits 3:2 read back the strapped slave address, 0x68 upward.
// - Link config bits 7:6 select link level: 00 1.2V, 01 1.8V, 1x 3.3V.
// - Link config bits 5:4 select one of four internal pull-up strengths.
// - Link config bit 1 sets power-off input level: 0 1.8V, 1 3.3V.
// - Link config bit 0 sets power-off acknowledge level: 0 1.2V, 1 1.8V.
// - Rail off bits 7..3 rails one to five, bit 2 linear; 1 off.
// - Gate bits 7..5 force external regulator enables off; bits 4:0 reserved.
// - Mode bits 7..3 per rail: 0 pulse skipping, 1 forced continuous PWM.
// - Mode bit 2 pairs rails two and three as dual phase; key locked.
// - Mode bit 1 pairs rails four and five as dual phase; key locked.
// - Mode bit 0 is reserved and reads zero.

// Register offsets
`define OFS_COMMON_LINK_CONFIG  8'h43
`define OFS_RAIL_OFF_CONTROL    8'h44
`define OFS_EXT_REGULATOR_GATE  8'h45
`define OFS_RAIL_MODE_SELECT    8'h46

// Field positions
`define LINK_VOLT_HI            7
`define LINK_VOLT_LO            6
`define LINK_PULL_HI            5
`define LINK_PULL_LO            4
`define LINK_ADDR_HI            3
`define LINK_ADDR_LO            2
`define LINK_PWROFF_IN          1
`define LINK_PWROFF_ACK         0
`define RAIL_FIELD_HI           7
`define RAIL_FIELD_LO           3
`define LINEAR_OFF_BIT          2
`define GATE_FIELD_HI           7
`define GATE_FIELD_LO           5
`define PAIR_BC_BIT             2
`define PAIR_DE_BIT             1

// Reset values
`define RST_LINK_CONFIG         6'h00
`define RST_RAIL_OFF            6'h00
`define RST_EXT_GATE            3'h0
`define RST_RAIL_MODE           5'h00
`define RST_PAIRS               2'h0

// Link addressing and timing
`define SLAVE_ADDR_BASE         7'h68
`define STRAP_SETTLE_CYCLES     3'h7
`endif

// >>> src/rail_config_bank.v
`timescale 1ns/1ps
`include "pmic_rail_config_defines.vh"
module rail_config_bank
(
   // Clock and reset
   input  wire       mclk,
   input  wire       nrst,
   // Write and read access
   input  wire       wrEn,
   input  wire [7:0] wrAddr,
   input  wire [7:0] wrData,
   input  wire [7:0] rdAddr,
   output reg  [7:0] rdData,
   // Lock and strap
   input  wire       testKeyUnlock,
   input  wire [1:0] addrSel,
   // Stored fields
   output reg  [5:0] linkCfg_q,
   output reg  [5:0] railOff_q,
   output reg  [2:0] extGate_q,
   output reg  [4:0] forcedPwm_q,
   output reg  [1:0] pairs_q
);

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         linkCfg_q   <= `RST_LINK_CONFIG;
         railOff_q   <= `RST_RAIL_OFF;
         extGate_q   <= `RST_EXT_GATE;
         forcedPwm_q <= `RST_RAIL_MODE;
         pairs_q     <= `RST_PAIRS;
      end
      else if (wrEn)
      begin
         if (wrAddr == `OFS_COMMON_LINK_CONFIG)
         begin
            // Address field bits are not stored
            linkCfg_q <= {wrData[`LINK_VOLT_HI:`LINK_PULL_LO],
                          wrData[`LINK_PWROFF_IN:`LINK_PWROFF_ACK]};
         end
         else if (wrAddr == `OFS_RAIL_OFF_CONTROL)
         begin
            railOff_q <= wrData[`RAIL_FIELD_HI:`LINEAR_OFF_BIT];
         end
         else if (wrAddr == `OFS_EXT_REGULATOR_GATE)
         begin
            extGate_q <= wrData[`GATE_FIELD_HI:`GATE_FIELD_LO];
         end
         else if (wrAddr == `OFS_RAIL_MODE_SELECT)
         begin
            forcedPwm_q <= wrData[`RAIL_FIELD_HI:`RAIL_FIELD_LO];
            if (testKeyUnlock)
            begin
               pairs_q <= wrData[`PAIR_BC_BIT:`PAIR_DE_BIT];
            end
         end
      end
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   always @*
   begin
      rdData = 8'h00;
      if (rdAddr == `OFS_COMMON_LINK_CONFIG)
      begin
         rdData = {linkCfg_q[5:2], addrSel, linkCfg_q[1:0]};
      end
      else if (rdAddr == `OFS_RAIL_OFF_CONTROL)
      begin
         rdData = {railOff_q, 2'h0};
      end
      else if (rdAddr == `OFS_EXT_REGULATOR_GATE)
      begin
         rdData = {extGate_q, 5'h00};
      end
      else if (rdAddr == `OFS_RAIL_MODE_SELECT)
      begin
         rdData = {forcedPwm_q, pairs_q, 1'b0};
      end
   end
endmodule

// >>> src/pmic_rail_config_regs.v
`timescale 1ns/1ps
`include "pmic_rail_config_defines.vh"
module pmic_rail_config_regs
(
   // Clock and reset
   input  wire       mclk,
   input  wire       nrst,
   // Serial link pins
   input  wire       scl,
   input  wire       sdaIn,
   output reg        sdaOut,
   output reg        sdaOe,
   // Strap and lock
   input  wire [1:0] addrStrap,
   input  wire       testKeyUnlock,
   // External regulator requests
   input  wire [2:0] extRegEnReq,
   // Link and power-off pin settings
   output wire [1:0] linkVoltageMode,
   output wire [1:0] linkPullupSel,
   output wire       powerOffInputLevel,
   output wire       powerOffAckLevel,
   // Rail control
   output wire [4:0] railOff,
   output wire       linearRegOff,
   output wire [4:0] railForcedPwm,
   output wire       pairBcDualPhase,
   output wire       pairDeDualPhase,
   // External regulator enables
   output reg  [2:0] extRegEnableOut
);

   localparam IDLE      = 4'h0;
   localparam ADDR      = 4'h1;
   localparam ADDR_ACK  = 4'h2;
   localparam PTR       = 4'h3;
   localparam PTR_ACK   = 4'h4;
   localparam WDATA     = 4'h5;
   localparam WDATA_ACK = 4'h6;
   localparam RDATA     = 4'h7;
   localparam RDATA_ACK = 4'h8;

   reg  [3:0] sync1_q;
   reg  [3:0] sync2_q;
   reg  [3:0] sync3_q;
   reg  [3:0] filt_q;
   reg        sclPrev_q;
   reg        sdaPrev_q;
   reg  [2:0] strapCnt_q;
   reg  [1:0] addrSel_q;
   reg  [3:0] state_q;
   reg  [3:0] bitCnt_q;
   reg  [7:0] shift_q;
   reg  [7:0] ptr_q;
   reg        readMode_q;
   reg        hostNack_q;
   reg        wrEn_q;
   reg  [7:0] wrData_q;
   wire       sclF;
   wire       sdaF;
   wire       sclRise;
   wire       sclFall;
   wire       startCond;
   wire       stopCond;
   wire [6:0] devAddr;
   wire [7:0] rdData;
   wire [5:0] linkCfg;
   wire [5:0] railOffBits;
   wire [2:0] extGate;
   wire [1:0] pairs;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1)
      begin : gSync
         wire pinIn;
         if (i == 0)
         begin : gScl
            assign pinIn = scl;
         end
         else if (i == 1)
         begin : gSda
            assign pinIn = sdaIn;
         end
         else
         begin : gStrap
            assign pinIn = addrStrap[i-2];
         end
         always @(posedge mclk or negedge nrst)
         begin
            if (!nrst)
            begin
               sync1_q[i] <= 1'b1;
               sync2_q[i] <= 1'b1;
               sync3_q[i] <= 1'b1;
               filt_q[i]  <= 1'b1;
            end
            else
            begin
               sync1_q[i] <= pinIn;
               sync2_q[i] <= sync1_q[i];
               sync3_q[i] <= sync2_q[i];
               if (sync2_q[i] == sync3_q[i])
               begin
                  filt_q[i] <= sync3_q[i];
               end
            end
         end
      end
   endgenerate

   assign sclF      = filt_q[0];
   assign sdaF      = filt_q[1];
   assign sclRise   = sclF & ~sclPrev_q;
   assign sclFall   = ~sclF & sclPrev_q;
   assign startCond = sclF & sclPrev_q & sdaPrev_q & ~sdaF;
   assign stopCond  = sclF & sclPrev_q & ~sdaPrev_q & sdaF;
   assign devAddr   = `SLAVE_ADDR_BASE + {5'h00, addrSel_q};

   // ----------------------------------------
   // Address strap capture after reset
   // ----------------------------------------
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         strapCnt_q <= 3'h0;
         addrSel_q  <= 2'h0;
      end
      else if (strapCnt_q != `STRAP_SETTLE_CYCLES)
      begin
         strapCnt_q <= strapCnt_q + 3'h1;
         addrSel_q  <= filt_q[3:2];
      end
   end

   // ----------------------------------------
   // Serial link target engine
   // ----------------------------------------
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         sclPrev_q  <= 1'b1;
         sdaPrev_q  <= 1'b1;
         state_q    <= IDLE;
         bitCnt_q   <= 4'h0;
         shift_q    <= 8'h00;
         ptr_q      <= 8'h00;
         readMode_q <= 1'b0;
         hostNack_q <= 1'b0;
         wrEn_q     <= 1'b0;
         wrData_q   <= 8'h00;
         sdaOut     <= 1'b0;
         sdaOe      <= 1'b0;
      end
      else
      begin
         sclPrev_q <= sclF;
         sdaPrev_q <= sdaF;
         wrEn_q    <= 1'b0;
         sdaOut    <= 1'b0;
         if (startCond)
         begin
            state_q  <= ADDR;
            bitCnt_q <= 4'h0;
            sdaOe    <= 1'b0;
         end
         else if (stopCond)
         begin
            state_q <= IDLE;
            sdaOe   <= 1'b0;
         end
         else
         begin
            case (state_q)
               ADDR, PTR, WDATA:
               begin
                  if (sclRise)
                  begin
                     shift_q  <= {shift_q[6:0], sdaF};
                     bitCnt_q <= bitCnt_q + 4'h1;
                  end
                  else if (sclFall && bitCnt_q == 4'h8)
                  begin
                     bitCnt_q <= 4'h0;
                     if (state_q == ADDR)
                     begin
                        if (shift_q[7:1] == devAddr)
                        begin
                           readMode_q <= shift_q[0];
                           sdaOe      <= 1'b1;
                           state_q    <= ADDR_ACK;
                        end
                        else
                        begin
                           state_q <= IDLE;
                        end
                     end
                     else if (state_q == PTR)
                     begin
                        ptr_q   <= shift_q;
                        sdaOe   <= 1'b1;
                        state_q <= PTR_ACK;
                     end
                     else
                     begin
                        wrEn_q   <= 1'b1;
                        wrData_q <= shift_q;
                        sdaOe    <= 1'b1;
                        state_q  <= WDATA_ACK;
                     end
                  end
               end
               ADDR_ACK:
               begin
                  if (sclFall)
                  begin
                     if (readMode_q)
                     begin
                        shift_q <= rdData;
                        sdaOe   <= ~rdData[7];
                        state_q <= RDATA;
                     end
                     else
                     begin
                        sdaOe   <= 1'b0;
                        state_q <= PTR;
                     end
                  end
               end
               PTR_ACK, WDATA_ACK:
               begin
                  if (sclFall)
                  begin
                     sdaOe   <= 1'b0;
                     state_q <= WDATA;
                     if (state_q == WDATA_ACK)
                     begin
                        ptr_q <= ptr_q + 8'h01;
                     end
                  end
               end
               RDATA:
               begin
                  if (sclRise)
                  begin
                     bitCnt_q <= bitCnt_q + 4'h1;
                  end
                  else if (sclFall)
                  begin
                     if (bitCnt_q == 4'h8)
                     begin
                        bitCnt_q <= 4'h0;
                        sdaOe    <= 1'b0;
                        state_q  <= RDATA_ACK;
                     end
                     else
                     begin
                        shift_q <= {shift_q[6:0], 1'b0};
                        sdaOe   <= ~shift_q[6];
                     end
                  end
               end
               RDATA_ACK:
               begin
                  if (sclRise)
                  begin
                     hostNack_q <= sdaF;
                     ptr_q      <= ptr_q + 8'h01;
                  end
                  else if (sclFall)
                  begin
                     if (hostNack_q)
                     begin
                        state_q <= IDLE;
                     end
                     else
                     begin
                        shift_q <= rdData;
                        sdaOe   <= ~rdData[7];
                        state_q <= RDATA;
                     end
                  end
               end
               default:
               begin
                  sdaOe <= 1'b0;
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // Register bank
   // ----------------------------------------
   rail_config_bank uBank
   (
      .mclk          (mclk),
      .nrst          (nrst),
      .wrEn          (wrEn_q),
      .wrAddr        (ptr_q),
      .wrData        (wrData_q),
      .rdAddr        (ptr_q),
      .rdData        (rdData),
      .testKeyUnlock (testKeyUnlock),
      .addrSel       (addrSel_q),
      .linkCfg_q     (linkCfg),
      .railOff_q     (railOffBits),
      .extGate_q     (extGate),
      .forcedPwm_q   (railForcedPwm),
      .pairs_q       (pairs)
   );

   assign linkVoltageMode    = linkCfg[5:4];
   assign linkPullupSel      = linkCfg[3:2];
   assign powerOffInputLevel = linkCfg[1];
   assign powerOffAckLevel   = linkCfg[0];
   assign railOff            = railOffBits[5:1];
   assign linearRegOff       = railOffBits[0];
   assign pairBcDualPhase    = pairs[1];
   assign pairDeDualPhase    = pairs[0];

   // ----------------------------------------
   // External regulator enable gating
   // ----------------------------------------
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         extRegEnableOut <= 3'h0;
      end
      else
      begin
         extRegEnableOut <= extRegEnReq &
                            ~{extGate[0], extGate[1], extGate[2]};
      end
   end
endmodule

// >>> tb/pmic_rail_config_props.sv
`timescale 1ns/1ps
module pmic_rail_config_props
(
   // Clock and reset
   input wire       mclk,
   input wire       nrst,
   // Serial link
   input wire       scl,
   input wire       sdaOut,
   input wire       sdaOe,
   // Lock and requests
   input wire       testKeyUnlock,
   input wire [2:0] extRegEnReq,
   // Settings
   input wire [1:0] linkVoltageMode,
   input wire [1:0] linkPullupSel,
   input wire       powerOffInputLevel,
   input wire       powerOffAckLevel,
   input wire [4:0] railOff,
   input wire       linearRegOff,
   input wire [4:0] railForcedPwm,
   input wire       pairBcDualPhase,
   input wire       pairDeDualPhase,
   input wire [2:0] extRegEnableOut
);
   // ----
   // Properties
   // ----
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   sequence sclLowRun;
      !scl [*3];
   endsequence
   sequence reqSteady;
      $stable(extRegEnReq) [*2];
   endsequence
   a_link_write_time: assert property (
      $changed({linkVoltageMode, linkPullupSel, powerOffInputLevel,
         powerOffAckLevel}) |-> sclLowRun)
      else $error("link settings changed outside a write");
   a_rail_off_time: assert property (
      $changed({railOff, linearRegOff}) |-> sclLowRun)
      else $error("rail off changed outside a write");
   a_mode_write_time: assert property (
      $changed(railForcedPwm) |-> sclLowRun)
      else $error("rail mode changed outside a write");
   a_pair_key_lock: assert property (
      $changed({pairBcDualPhase, pairDeDualPhase}) |->
         $past(testKeyUnlock, 1))
      else $error("pairing changed while locked");
   a_gate_write_time: assert property (
      reqSteady ##1 $changed(extRegEnableOut) |-> sclLowRun)
      else $error("enable gating changed outside a write");
   a_out_needs_req: assert property (
      (extRegEnableOut & ~$past(extRegEnReq)) == 3'h0)
      else $error("enable out without request");
   a_ack_drive_low: assert property (
      $rose(sdaOe) |-> !scl ##1 sdaOe [*8])
      else $error("data drive not held in clock low");
   a_release_low: assert property (
      $fell(sdaOe) |-> !scl)
      else $error("data released while clock high");
   a_open_drain: assert property (
      sdaOe |-> !sdaOut)
      else $error("data line driven high");
endmodule

bind pmic_rail_config_regs pmic_rail_config_props i_props
(
   .mclk(mclk), .nrst(nrst), .scl(scl), .sdaOut(sdaOut), .sdaOe(sdaOe),
   .testKeyUnlock(testKeyUnlock), .extRegEnReq(extRegEnReq),
   .linkVoltageMode(linkVoltageMode), .linkPullupSel(linkPullupSel),
   .powerOffInputLevel(powerOffInputLevel),
   .powerOffAckLevel(powerOffAckLevel), .railOff(railOff),
   .linearRegOff(linearRegOff), .railForcedPwm(railForcedPwm),
   .pairBcDualPhase(pairBcDualPhase), .pairDeDualPhase(pairDeDualPhase),
   .extRegEnableOut(extRegEnableOut)
);

// >>> tb/i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model
(
   // Clock
   input  wire       mclk,
   // Serial link
   input  wire       sda,
   output reg        scl,
   output reg        sdaPull,
   // Read results
   output reg        rdValid,
   output reg  [7:0] rdByte
);
   // ----
   // Bus cycles
   // ----
   localparam int HALF = 12;
   initial
   begin
      scl = 1'b1;
      sdaPull = 1'b0;
      rdValid = 1'b0;
      rdByte = 8'h00;
   end
   task automatic bitXfer(input logic b, output logic s);
      repeat (2) @(posedge mclk);
      sdaPull <= ~b;
      repeat (HALF) @(posedge mclk);
      scl <= 1'b1;
      repeat (HALF) @(posedge mclk);
      s = sda;
      scl <= 1'b0;
   endtask
   task automatic start;
      repeat (2) @(posedge mclk);
      sdaPull <= 1'b0;
      repeat (HALF) @(posedge mclk);
      scl <= 1'b1;
      repeat (HALF) @(posedge mclk);
      sdaPull <= 1'b1;
      repeat (HALF) @(posedge mclk);
      scl <= 1'b0;
   endtask
   task automatic stop;
      repeat (2) @(posedge mclk);
      sdaPull <= 1'b1;
      repeat (HALF) @(posedge mclk);
      scl <= 1'b1;
      repeat (HALF) @(posedge mclk);
      sdaPull <= 1'b0;
      repeat (HALF) @(posedge mclk);
   endtask
   task automatic sendByte(input logic [7:0] d, output logic nak);
      logic s;
      for (int i = 7; i >= 0; i--)
         bitXfer(d[i], s);
      bitXfer(1'b1, nak);
   endtask
   task automatic wrReg(input logic [6:0] dev, input logic [7:0] ptr,
                        input logic [7:0] d, output logic nak);
      logic n1, n2, n3;
      start();
      sendByte({dev, 1'b0}, n1);
      sendByte(ptr, n2);
      sendByte(d, n3);
      stop();
      nak = n1 | n2 | n3;
   endtask
   task automatic rdReg(input logic [6:0] dev, input logic [7:0] ptr);
      logic       n;
      logic [7:0] d;
      start();
      sendByte({dev, 1'b0}, n);
      sendByte(ptr, n);
      start();
      sendByte({dev, 1'b1}, n);
      for (int i = 7; i >= 0; i--)
         bitXfer(1'b1, d[i]);
      bitXfer(1'b1, n);
      stop();
      rdByte <= d;
      rdValid <= 1'b1;
      @(posedge mclk);
      rdValid <= 1'b0;
   endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   // ----
   // Signals
   // ----
   logic       mclk = 1'b0;
   logic       nrst = 1'b0;
   logic [1:0] addrStrap = 2'h0;
   logic       testKeyUnlock = 1'b0;
   logic [2:0] extRegEnReq = 3'h0;
   wire        scl, sda, sdaPull, sdaOut, sdaOe, rdValid;
   wire  [7:0] rdByte;
   wire  [1:0] linkVoltageMode, linkPullupSel;
   wire        powerOffInputLevel, powerOffAckLevel, linearRegOff;
   wire        pairBcDualPhase, pairDeDualPhase;
   wire  [4:0] railOff, railForcedPwm;
   wire  [2:0] extRegEnableOut;
   wire  [6:0] devAddr;
   logic [7:0] shadow [0:3] = '{default: 8'h00};
   logic [7:0] expQ [$];
   int         miscompares = 0;
   int         testsRun = 0;

   always #5 mclk = ~mclk;
   assign sda = ~((sdaOe & ~sdaOut) | sdaPull);
   assign devAddr = 7'h68 + {5'h00, addrStrap};

   pmic_rail_config_regs i_dut
   (
      .mclk(mclk), .nrst(nrst), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut),
      .sdaOe(sdaOe), .addrStrap(addrStrap), .testKeyUnlock(testKeyUnlock),
      .extRegEnReq(extRegEnReq), .linkVoltageMode(linkVoltageMode),
      .linkPullupSel(linkPullupSel), .powerOffInputLevel(powerOffInputLevel),
      .powerOffAckLevel(powerOffAckLevel), .railOff(railOff),
      .linearRegOff(linearRegOff), .railForcedPwm(railForcedPwm),
      .pairBcDualPhase(pairBcDualPhase), .pairDeDualPhase(pairDeDualPhase),
      .extRegEnableOut(extRegEnableOut)
   );
   i2c_host_model i_host
   (
      .mclk(mclk), .sda(sda), .scl(scl), .sdaPull(sdaPull),
      .rdValid(rdValid), .rdByte(rdByte)
   );

   // ----
   // Checking
   // ----
   task automatic chk(input string what, input logic [7:0] e,
                      input logic [7:0] g);
      testsRun++;
      if (g !== e)
      begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", testsRun, miscompares);
      if (miscompares == 0 && testsRun > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge mclk)
      if (rdValid === 1'b1)
      begin
         if (expQ.size() == 0)
            chk("read count", 8'h00, 8'h01);
         else
            chk("read data", expQ.pop_front(), rdByte);
      end
   function automatic logic [7:0] nxt(input int r, input logic [7:0] d,
                                      input logic [7:0] o, input logic k);
      case (r)
         0: return {d[7:4], 2'b00, d[1:0]};
         1: return d & 8'hFC;
         2: return d & 8'hE0;
         default: return {d[7:3], k ? d[2:1] : o[2:1], 1'b0};
      endcase
   endfunction
   task automatic portChk;
      chk("link pins", {linkVoltageMode, linkPullupSel, 2'b00,
          powerOffInputLevel, powerOffAckLevel}, shadow[0]);
      chk("rail off", {railOff, linearRegOff, 2'b00}, shadow[1]);
      chk("rail mode", {railForcedPwm, pairBcDualPhase, pairDeDualPhase,
          1'b0}, shadow[3]);
      chk("ext enables", {5'h00, extRegEnReq & ~{shadow[2][5],
          shadow[2][6], shadow[2][7]}}, {5'h00, extRegEnableOut});
   endtask
   task automatic wr(input logic [6:0] dev, input int r, input logic [7:0] d);
      logic nak;
      i_host.wrReg(dev, 8'h43 + 8'(r), d, nak);
      chk("write ack", {7'h00, dev !== devAddr}, {7'h00, nak});
      if (dev === devAddr && r < 4)
         shadow[r] = nxt(r, d, shadow[r], testKeyUnlock);
      repeat (2) @(posedge mclk);
      portChk();
   endtask
   task automatic rd(input int r);
      expQ.push_back(r > 3 ? 8'h00 : shadow[r] |
         (r == 0 ? {4'h0, addrStrap, 2'b00} : 8'h00));
      i_host.rdReg(devAddr, 8'h43 + 8'(r));
   endtask

   // ----
   // Sequence
   // ----
   initial
   begin
      int         r;
      logic [7:0] d;
      void'($urandom(32'hE5A34856));
      addrStrap <= 2'($urandom);
      repeat (20) @(posedge mclk);
      nrst <= 1'b1;
      repeat (20) @(posedge mclk);
      for (r = 0; r < 5; r++)
         rd(r);
      portChk();
      wr(devAddr ^ 7'h04, 1, 8'hFF);
      extRegEnReq <= 3'h7;
      for (int i = 0; i < 8; i++)
      begin
         testKeyUnlock <= i[0];
         wr(devAddr, 2, {i[2:0], 5'h1F});
         wr(devAddr, 3, {5'h00, i[2:1], 1'b1});
      end
      for (int n = 0; n < 30; n++)
      begin
         r = $urandom_range(4);
         d = 8'($urandom);
         if (r == 3)
         begin
            d[5] = d[6];
            d[3] = d[4];
         end
         @(posedge mclk);
         testKeyUnlock <= 1'($urandom);
         extRegEnReq <= 3'($urandom);
         repeat (2) @(posedge mclk);
         wr(devAddr, r, d);
         rd(r);
      end
      repeat (4) @(posedge mclk);
      chk("pending reads", 8'h00, 8'(expQ.size()));
      conclude();
   end
   initial
   begin
      repeat (90000) @(posedge mclk);
      miscompares++;
      $display("unexpected run length: expected done seen running");
      conclude();
   end
endmodule
